// File: verilog/sysctl_pkg.sv
// constants for the reset, watchdog and interrupt sequencing block
`default_nettype none
package sysctl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RST_STATUS = 8'h00;
  localparam logic [7:0] OFS_SYS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h10;
  localparam logic [7:0] OFS_STACK_PTR = 8'h14;
  // reset status bit positions
  localparam int POS_POR = 7;
  localparam int POS_PIN = 6;
  localparam int POS_WDOG = 5;
  localparam int POS_ILOP = 4;
  localparam int POS_LOC = 2;
  localparam int POS_LVD = 1;
  localparam logic [7:0] RST_STATUS_RESET = 8'h80;
  // system options fields
  localparam int POS_WD_EN = 0;
  localparam int POS_WD_TSEL = 1;
  localparam int POS_LOCKED = 2;
  localparam logic WD_EN_RESET = 1'h1;
  localparam logic WD_TSEL_RESET = 1'h1;
  // cpu state
  localparam int POS_CCR_I = 3;
  localparam logic [7:0] CCR_RESET = 8'h08;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] VEC_BASE = 16'hffc0;
  localparam logic [2:0] STACK_LAST = 3'h4;
  localparam logic [2:0] FILL_LAST = 3'h2;
  // reset pin timing in bus cycles
  localparam logic [6:0] DRIVE_BUS_CYCLES = 7'h22;
  localparam logic [6:0] SAMPLE_BUS_CYCLES = 7'h26;
  typedef enum logic [1:0] {RST_DRIVE, RST_WAIT, RST_RUN} rst_state_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_PUSH, SQ_VEC, SQ_FILL, SQ_POP} seq_state_t;
endpackage
`default_nettype wire

// File: verilog/reset_watchdog_interrupt_ctrl.sv
// reset sequencing, watchdog and interrupt entry/return sequencer
// How it works
// RL1 - during reset registers take initial values; pc loads from vector at top
// RL2 - reset disables peripherals and parks every pin as plain input
// RL3 - reset sets the global interrupt mask bit
// RL4 - reset loads the stack pointer with its fixed start value
// RL5 - seven reset sources; all but debug-forced leave a status flag
// RL6 - in reset the clock generator self-clocks; bus runs at half rate
// RL7 - reset pin is driven low for 34 bus cycles, then released
// RL8 - 38 bus cycles after release the pin is sampled for pin cause
// RL9 - an enabled watchdog reaching timeout resets the system
// RL10 - any write to the status address clears the watchdog, data unchanged
// RL11 - watchdog enabled after reset; options register is write-once
// RL12 - timeout select picks 2^18 or 2^13 bus cycles
// RL13 - watchdog halts while background debug is active
// RL14 - events set flags; cpu asked only if enabled and mask clear
// RL15 - current instruction completes before interrupt entry starts
// RL16 - entry stacks, masks, fetches vector, fills three queue bytes
// RL17 - pcl pushed first, ccr last; sp ends one below ccr
// RL18 - stacked pc is the next instruction's address
// RL19 - return pops ccr, a, x, pc then refills three bytes
// RL20 - the upper index register is never saved or restored
// RL21 - highest-priority pending source is serviced first
// RL22 - in stop mode an asynchronous path lets the interrupt pin wake
// RL23 - watchdog counter cleared by reset, counts each bus cycle
// RL24 - software locks options once and services from main loop
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module reset_watchdog_interrupt_ctrl #(
  parameter int unsigned WD_LONG_CYCLES = 262144,
  parameter int unsigned WD_SHORT_CYCLES = 8192
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOen,
  input wire logic lvdDetect,
  input wire logic clockLossReset,
  input wire logic illegalOpcode,
  input wire logic debugForceReset,
  input wire logic bdmActive,
  output logic sysReset,
  output logic icgSelfClock,
  output logic pinsDefault,
  input wire logic [7:0] srcEvent,
  input wire logic instrDone,
  input wire logic rtiStart,
  input wire logic [15:0] pcNext,
  input wire logic [7:0] accIn,
  input wire logic [7:0] idxIn,
  input wire logic [7:0] ccrIn,
  output logic memReq,
  output logic memWr,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic memAck,
  output logic [7:0] queueByte,
  output logic queueValid,
  output logic [15:0] pcOut,
  output logic [15:0] spOut,
  output logic [7:0] accOut,
  output logic [7:0] idxOut,
  output logic [7:0] ccrOut,
  output logic cpuHold,
  input wire logic stopMode,
  input wire logic irqPinEnable,
  input wire logic irqPinRaw,
  output logic stopWake
);
  localparam int I = sysctl_pkg::POS_CCR_I;

  function automatic logic [2:0] topSource(input logic [7:0] req);
    topSource = 3'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (req[k]) topSource = 3'(k); // higher index wins, see RL21
    end
  endfunction

  function automatic logic [15:0] offsetAddr(input logic [15:0] base, input logic [2:0] n);
    offsetAddr = base + {13'h0, n};
  endfunction

  // --------------------------------------------------------------
  // pin synchronisers and bus-rate divider
  // --------------------------------------------------------------
  logic [2:0] syncA_q, syncB_q;
  logic busEn_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_q <= 3'h7;
      syncB_q <= 3'h7;
      busEn_q <= 1'b0;
    end
    else
    begin
      syncA_q <= {resetPinIn, ~lvdDetect, ~clockLossReset};
      syncB_q <= syncA_q;
      busEn_q <= ~busEn_q; // bus clock is half the generator rate, see RL6
    end
  end
  wire logic pinLow = ~syncB_q[2];
  wire logic lvdSync = ~syncB_q[1];
  wire logic locSync = ~syncB_q[0];

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire logic apbDone = psel & penable & pready;
  wire logic apbWr = apbDone & pwrite;
  wire logic wrSrs = apbWr & (paddr == sysctl_pkg::OFS_RST_STATUS);
  wire logic wrSopt = apbWr & (paddr == sysctl_pkg::OFS_SYS_OPTIONS);
  wire logic wrFlags = apbWr & (paddr == sysctl_pkg::OFS_IRQ_FLAGS);
  wire logic wrEn = apbWr & (paddr == sysctl_pkg::OFS_IRQ_ENABLE);
  wire logic wrCcr = apbWr & (paddr == sysctl_pkg::OFS_CPU_CTRL);

  // --------------------------------------------------------------
  // reset sequencer
  // --------------------------------------------------------------
  sysctl_pkg::rst_state_t rst_q, rst_d;
  logic [6:0] rstCnt_q, rstCnt_d;
  logic [7:0] cause_q, cause_d, srs_q, srs_d;
  logic oen_q, oen_d, inReset_q, inReset_d;
  logic wdHit;
  logic [7:0] trig;
  always_comb
  begin
    trig = 8'h0;
    trig[sysctl_pkg::POS_LVD] = lvdSync;
    trig[sysctl_pkg::POS_LOC] = locSync;
    trig[sysctl_pkg::POS_ILOP] = illegalOpcode;
    trig[sysctl_pkg::POS_WDOG] = wdHit; // see RL9
    rst_d = rst_q;
    rstCnt_d = rstCnt_q;
    cause_d = cause_q;
    srs_d = srs_q;
    oen_d = oen_q;
    case (rst_q)
      sysctl_pkg::RST_DRIVE:
      begin
        oen_d = 1'b0;
        if (busEn_q)
        begin
          if (rstCnt_q == sysctl_pkg::DRIVE_BUS_CYCLES - 7'h1)
          begin
            rst_d = sysctl_pkg::RST_WAIT; // see RL7
            rstCnt_d = 7'h0;
            oen_d = 1'b1;
          end
          else
            rstCnt_d = rstCnt_q + 7'h1;
        end
      end
      sysctl_pkg::RST_WAIT:
      begin
        if (busEn_q)
        begin
          if (rstCnt_q == sysctl_pkg::SAMPLE_BUS_CYCLES - 7'h1)
          begin
            rst_d = sysctl_pkg::RST_RUN;
            srs_d = cause_q; // see RL5
            srs_d[sysctl_pkg::POS_PIN] = cause_q[sysctl_pkg::POS_PIN] | pinLow; // see RL8
            cause_d = 8'h0;
          end
          else
            rstCnt_d = rstCnt_q + 7'h1;
        end
      end
      sysctl_pkg::RST_RUN:
      begin
        // debug-forced reset enters reset but leaves no flag, see RL5
        if ((trig != 8'h0) || debugForceReset || pinLow)
        begin
          rst_d = sysctl_pkg::RST_DRIVE;
          rstCnt_d = 7'h0;
          cause_d = trig;
          // a short outside pulse is gone before the late sample, so keep it here, see RL5
          cause_d[sysctl_pkg::POS_PIN] = pinLow;
          oen_d = 1'b0;
        end
      end
      default: rst_d = sysctl_pkg::RST_DRIVE;
    endcase
    inReset_d = (rst_d != sysctl_pkg::RST_RUN);
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q <= sysctl_pkg::RST_DRIVE;
      rstCnt_q <= 7'h0;
      cause_q <= sysctl_pkg::RST_STATUS_RESET;
      srs_q <= sysctl_pkg::RST_STATUS_RESET;
      oen_q <= 1'b0;
      inReset_q <= 1'b1;
    end
    else
    begin
      rst_q <= rst_d;
      rstCnt_q <= rstCnt_d;
      cause_q <= cause_d;
      srs_q <= srs_d;
      oen_q <= oen_d;
      inReset_q <= inReset_d;
    end
  end
  assign resetPinOen = oen_q;
  assign resetPinOut = 1'b0;
  // one flop drives all three: peripherals off, pins parked, self-clocked, see RL2 RL6
  assign sysReset = inReset_q;
  assign pinsDefault = inReset_q;
  assign icgSelfClock = inReset_q;

  // --------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------
  logic [17:0] wdCnt_q, wdCnt_d;
  logic wdEn_q, wdEn_d, wdTsel_q, wdTsel_d, locked_q, locked_d;
  logic [17:0] wdLimit;
  always_comb
  begin
    wdLimit = wdTsel_q ? 18'(WD_LONG_CYCLES - 1) : 18'(WD_SHORT_CYCLES - 1); // see RL12
    wdHit = wdEn_q & busEn_q & ~bdmActive & (wdCnt_q == wdLimit);
    wdCnt_d = wdCnt_q;
    wdEn_d = wdEn_q;
    wdTsel_d = wdTsel_q;
    locked_d = locked_q;
    if (wdEn_q && busEn_q && !bdmActive) wdCnt_d = wdCnt_q + 18'h1; // see RL13 RL23
    if (wrSrs || wdHit) wdCnt_d = 18'h0; // see RL10
    if (wrSopt && !locked_q)
    begin
      wdEn_d = pwdata[sysctl_pkg::POS_WD_EN]; // see RL11
      wdTsel_d = pwdata[sysctl_pkg::POS_WD_TSEL];
      locked_d = 1'b1;
    end
    if (inReset_q)
    begin
      wdCnt_d = 18'h0;
      wdEn_d = sysctl_pkg::WD_EN_RESET;
      wdTsel_d = sysctl_pkg::WD_TSEL_RESET;
      locked_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdCnt_q <= 18'h0;
      wdEn_q <= sysctl_pkg::WD_EN_RESET;
      wdTsel_q <= sysctl_pkg::WD_TSEL_RESET;
      locked_q <= 1'b0;
    end
    else
    begin
      wdCnt_q <= wdCnt_d;
      wdEn_q <= wdEn_d;
      wdTsel_q <= wdTsel_d;
      locked_q <= locked_d;
    end
  end

  // --------------------------------------------------------------
  // apb slave: one wait state, reads captured before pready
  // --------------------------------------------------------------
  logic [7:0] flags_q, flags_d, irqEn_q, irqEn_d;
  logic [31:0] rdata_d;
  logic pready_d, pslverr_d;
  logic [15:0] sp_q;
  logic [7:0] ccr_q;
  always_comb
  begin
    pready_d = psel & penable & ~pready;
    pslverr_d = 1'b0;
    rdata_d = 32'h0;
    case (paddr)
      sysctl_pkg::OFS_RST_STATUS: rdata_d[7:0] = srs_q;
      sysctl_pkg::OFS_SYS_OPTIONS: rdata_d[2:0] = {locked_q, wdTsel_q, wdEn_q};
      sysctl_pkg::OFS_IRQ_FLAGS: rdata_d[7:0] = flags_q;
      sysctl_pkg::OFS_IRQ_ENABLE: rdata_d[7:0] = irqEn_q;
      sysctl_pkg::OFS_CPU_CTRL: rdata_d[0] = ccr_q[I];
      sysctl_pkg::OFS_STACK_PTR: rdata_d[15:0] = sp_q;
      default: pslverr_d = pready_d;
    endcase
    irqEn_d = wrEn ? pwdata[7:0] : irqEn_q;
    // a new event beats a clear in the same cycle, see RL14
    flags_d = (flags_q & ~(wrFlags ? pwdata[7:0] : 8'h0)) | srcEvent;
    if (inReset_q)
    begin
      irqEn_d = 8'h0;
      flags_d = 8'h0;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      flags_q <= 8'h0;
      irqEn_q <= 8'h0;
    end
    else
    begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= pready_d ? rdata_d : 32'h0;
      flags_q <= flags_d;
      irqEn_q <= irqEn_d;
    end
  end

  // --------------------------------------------------------------
  // interrupt entry / return sequencer
  // --------------------------------------------------------------
  sysctl_pkg::seq_state_t seq_q, seq_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] pc_q, pc_d, sp_d, vec_q, vec_d, addr_q, addr_d;
  logic [7:0] acc_q, acc_d, idx_q, idx_d, ccr_d, wdata_q, wdata_d, qByte_q, qByte_d;
  logic req_q, req_d, wr_q, wr_d, qValid_q, qValid_d, hold_q, hold_d;
  wire logic [7:0] pending = flags_q & irqEn_q;
  wire logic intReq = (pending != 8'h0) & ~ccr_q[I]; // see RL14
  always_comb
  begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    sp_d = sp_q;
    acc_d = acc_q;
    idx_d = idx_q;
    ccr_d = ccr_q;
    vec_d = vec_q;
    req_d = req_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    qByte_d = qByte_q;
    qValid_d = 1'b0;
    if (wrCcr) ccr_d[I] = pwdata[0];
    case (seq_q)
      sysctl_pkg::SQ_IDLE:
      begin
        if (rtiStart)
        begin
          seq_d = sysctl_pkg::SQ_POP;
          cnt_d = 3'h0;
        end
        else if (instrDone && intReq) // see RL15
        begin
          seq_d = sysctl_pkg::SQ_PUSH;
          cnt_d = 3'h0;
          pc_d = pcNext; // see RL18
          acc_d = accIn;
          idx_d = idxIn; // only the low index byte, see RL20
          ccr_d = ccrIn;
          ccr_d[I] = ccr_q[I];
          vec_d = VEC_BASE_OF(topSource(pending)); // see RL21
        end
      end
      sysctl_pkg::SQ_PUSH:
      begin
        if (!req_q)
        begin
          req_d = 1'b1;
          wr_d = 1'b1;
          addr_d = sp_q;
          case (cnt_q) // see RL17
            3'h0: wdata_d = pc_q[7:0];
            3'h1: wdata_d = pc_q[15:8];
            3'h2: wdata_d = idx_q;
            3'h3: wdata_d = acc_q;
            default: wdata_d = ccr_q;
          endcase
        end
        else if (memAck)
        begin
          req_d = 1'b0;
          sp_d = sp_q - 16'h1;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == sysctl_pkg::STACK_LAST)
          begin
            seq_d = sysctl_pkg::SQ_VEC; // see RL16
            cnt_d = 3'h0;
            ccr_d[I] = 1'b1;
          end
        end
      end
      sysctl_pkg::SQ_VEC:
      begin
        if (!req_q)
        begin
          req_d = 1'b1;
          wr_d = 1'b0;
          addr_d = offsetAddr(vec_q, cnt_q);
        end
        else if (memAck)
        begin
          req_d = 1'b0;
          cnt_d = 3'h1;
          if (cnt_q == 3'h0)
            pc_d[15:8] = memRdata;
          else
          begin
            pc_d[7:0] = memRdata;
            seq_d = sysctl_pkg::SQ_FILL;
            cnt_d = 3'h0;
          end
        end
      end
      sysctl_pkg::SQ_FILL:
      begin
        if (!req_q)
        begin
          req_d = 1'b1;
          wr_d = 1'b0;
          addr_d = offsetAddr(pc_q, cnt_q);
        end
        else if (memAck)
        begin
          req_d = 1'b0;
          qByte_d = memRdata;
          qValid_d = 1'b1;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == sysctl_pkg::FILL_LAST) seq_d = sysctl_pkg::SQ_IDLE; // see RL16 RL19
        end
      end
      sysctl_pkg::SQ_POP:
      begin
        if (!req_q)
        begin
          req_d = 1'b1;
          wr_d = 1'b0;
          addr_d = sp_q + 16'h1;
        end
        else if (memAck)
        begin
          req_d = 1'b0;
          sp_d = sp_q + 16'h1;
          cnt_d = cnt_q + 3'h1;
          case (cnt_q) // reverse of the push order, see RL19
            3'h0: ccr_d = memRdata;
            3'h1: acc_d = memRdata;
            3'h2: idx_d = memRdata;
            3'h3: pc_d[15:8] = memRdata;
            default:
            begin
              pc_d[7:0] = memRdata;
              seq_d = sysctl_pkg::SQ_FILL;
              cnt_d = 3'h0;
            end
          endcase
        end
      end
      default: seq_d = sysctl_pkg::SQ_IDLE;
    endcase
    if (inReset_q)
    begin
      // abandon any access; boot fetches the reset vector on release, see RL1
      seq_d = sysctl_pkg::SQ_VEC;
      vec_d = sysctl_pkg::RESET_VECTOR;
      cnt_d = 3'h0;
      req_d = 1'b0;
      sp_d = sysctl_pkg::SP_RESET; // see RL4
      ccr_d[I] = 1'b1; // see RL3
    end
    hold_d = inReset_d | (seq_d != sysctl_pkg::SQ_IDLE);
  end
  function automatic logic [15:0] VEC_BASE_OF(input logic [2:0] src);
    VEC_BASE_OF = sysctl_pkg::VEC_BASE + {12'h0, src, 1'b0};
  endfunction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_q <= sysctl_pkg::SQ_VEC;
      cnt_q <= 3'h0;
      pc_q <= 16'h0;
      sp_q <= sysctl_pkg::SP_RESET;
      acc_q <= 8'h0;
      idx_q <= 8'h0;
      ccr_q <= sysctl_pkg::CCR_RESET;
      vec_q <= sysctl_pkg::RESET_VECTOR;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0;
      wdata_q <= 8'h0;
      qByte_q <= 8'h0;
      qValid_q <= 1'b0;
      hold_q <= 1'b1;
    end
    else
    begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      ccr_q <= ccr_d;
      vec_q <= vec_d;
      req_q <= req_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      qByte_q <= qByte_d;
      qValid_q <= qValid_d;
      hold_q <= hold_d;
    end
  end
  assign memReq = req_q;
  assign memWr = wr_q;
  assign memAddr = addr_q;
  assign memWdata = wdata_q;
  assign queueByte = qByte_q;
  assign queueValid = qValid_q;
  assign pcOut = pc_q;
  assign spOut = sp_q;
  assign accOut = acc_q;
  assign idxOut = idx_q;
  assign ccrOut = ccr_q;
  assign cpuHold = hold_q;
  // no clock runs in stop mode, so this wake path is gates only
  assign stopWake = stopMode & irqPinEnable & ~irqPinRaw; // see RL22

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [6:0] drvCnt_q, waitCnt_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drvCnt_q <= 7'h0;
      waitCnt_q <= 7'h0;
    end
    else
    begin
      drvCnt_q <= oen_q ? 7'h0 : drvCnt_q + 7'(busEn_q);
      waitCnt_q <= (rst_q == sysctl_pkg::RST_WAIT) ? waitCnt_q + 7'(busEn_q) : 7'h0;
    end
  end
  a_drive_length: assert property (@(posedge clk) disable iff (!arst_n) // see RL7
    $rose(oen_q) |-> drvCnt_q == sysctl_pkg::DRIVE_BUS_CYCLES) else $error("reset pin drive length wrong");
  a_sample_delay: assert property (@(posedge clk) disable iff (!arst_n) // see RL8
    $fell(inReset_q) |-> waitCnt_q == sysctl_pkg::SAMPLE_BUS_CYCLES) else $error("pin sampled at wrong time");
  a_boot_state: assert property (@(posedge clk) disable iff (!arst_n) // see RL3
    $fell(inReset_q) |-> ccr_q[I] && sp_q == 16'h00ff && !pslverr) else $error("bad state after reset");
  a_boot_vector: assert property (@(posedge clk) disable iff (!arst_n) // see RL1
    $fell(inReset_q) |-> ##1 memReq && !memWr && memAddr == 16'hfffe) else $error("reset vector not fetched");
  a_reset_outputs: assert property (@(posedge clk) disable iff (!arst_n) // see RL2
    !oen_q |-> sysReset && pinsDefault && icgSelfClock && cpuHold) else $error("reset outputs inconsistent");
  a_wd_timeout: assert property (@(posedge clk) disable iff (!arst_n) // see RL9
    wdHit |=> !oen_q && cause_q[sysctl_pkg::POS_WDOG]) else $error("watchdog timeout missed");
  a_wd_service: assert property (@(posedge clk) disable iff (!arst_n) // see RL10
    wrSrs && !inReset_q |=> wdCnt_q == 18'h0 && $stable(srs_q)) else $error("watchdog service wrong");
  a_wd_bdm_hold: assert property (@(posedge clk) disable iff (!arst_n) // see RL13
    bdmActive && !wrSrs && !inReset_q |=> $stable(wdCnt_q)) else $error("watchdog ran in debug");
  a_system_options_reg_lock: assert property (@(posedge clk) disable iff (!arst_n) // see RL11
    locked_q && !inReset_q |=> $stable({wdEn_q, wdTsel_q})) else $error("options changed after lock");
  a_entry_qual: assert property (@(posedge clk) disable iff (!arst_n) // see RL14
    seq_q == sysctl_pkg::SQ_IDLE && seq_d == sysctl_pkg::SQ_PUSH |-> !ccr_q[I] && pending != 8'h0 && instrDone)
    else $error("unqualified interrupt entry");
  a_stack_first: assert property (@(posedge clk) disable iff (!arst_n) // see RL17
    $rose(seq_q == sysctl_pkg::SQ_PUSH) |=> memWr && memAddr == $past(sp_q) && memWdata == pc_q[7:0])
    else $error("first stacked byte wrong");
  a_vector_masked: assert property (@(posedge clk) disable iff (!arst_n) // see RL16
    seq_q == sysctl_pkg::SQ_VEC |-> ccr_q[I]) else $error("vector fetch with mask clear");
endmodule
`default_nettype wire

// File: verification/sysctl_partner.sv
// far side: cpu memory with slow answers and the reset pin's outside circuit
`timescale 1ns/10ps
`default_nettype none
module sysctl_partner (
  input wire logic clk,
  input wire logic memReq,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  output logic memAck,
  input wire logic pinOen,
  input wire logic pinOut,
  input wire logic extLow,
  output logic pinLevel
);
  logic [7:0] mem [65536];
  logic [24:0] log [$];
  int wt = 0;
  // pullup raises the pin unless the device or the outside pulls it low
  assign pinLevel = !pinOen ? pinOut : !extLow;
  initial
  begin
    memAck = 1'b0;
    memRdata = 8'h00;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i ^ (i >> 8));
  end
  // data lines toggle when not answering, so stale data never matches
  always @(posedge clk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck)
    begin
      if (wt == 0)
        wt = 1 + $urandom % 3;
      else
      begin
        wt = wt - 1;
        if (wt == 0)
        begin
          if (memWr)
            mem[memAddr] = memWdata;
          memAck <= 1'b1;
          memRdata <= mem[memAddr];
          log.push_back({memWr, memAddr, mem[memAddr]});
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/reset_watchdog_interrupt_ctrl_tb_top.sv
// bench: reset causes, watchdog and interrupt entry/return against a queue model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t differs", $time); end end
`define WAITC(c) begin int k = 0; while (!(c) && k < 2000) begin @(posedge clk); k++; end if (k >= 2000) tmo(); end
module reset_watchdog_interrupt_ctrl_tb_top;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, extLow = 0, low_voltage_detect = 0, cLoss = 0, ilop = 0;
  logic dbgRst = 0, bdm = 0, instrDone = 0, rtiStart = 0, stopMode = 0, irqPinEnable = 0, irqPinRaw = 0;
  logic [7:0] paddr = 0, srcEvent = 0, accIn = 0, idxIn = 0, ccrIn = 0, memWdata, memRdata, accOut, idxOut, ccrOut;
  logic [15:0] pcNext = 0, memAddr, spOut, pcOut;
  logic [31:0] pwdata = 0, r, prdata;
  logic err, pready, pslverr, pinOut, pinOen, pinLvl, sysReset, internal_clock_generator, pinsDef, memReq, memWr, memAck, cpuHold, stopWake;
  logic [24:0] exq [$];
  logic [7:0] srcFlag [5] = '{8'h02, 8'h04, 8'h10, 8'h00, 8'h40};
  int mismatches = 0, nCompared = 0;
  reset_watchdog_interrupt_ctrl #(.WD_LONG_CYCLES(64), .WD_SHORT_CYCLES(16)) DUT (.clk, .arst_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .resetPinIn(pinLvl), .resetPinOut(pinOut),
    .resetPinOen(pinOen), .lvdDetect(low_voltage_detect), .clockLossReset(cLoss), .illegalOpcode(ilop), .debugForceReset(dbgRst),
    .bdmActive(bdm), .sysReset, .icgSelfClock(internal_clock_generator), .pinsDefault(pinsDef), .srcEvent, .instrDone, .rtiStart,
    .pcNext, .accIn, .idxIn, .ccrIn, .memReq, .memWr, .memAddr, .memWdata, .memRdata, .memAck, .queueByte(),
    .queueValid(), .pcOut, .spOut, .accOut, .idxOut, .ccrOut, .cpuHold, .stopMode, .irqPinEnable, .irqPinRaw,
    .stopWake);
  sysctl_partner P (.clk, .memReq, .memWr, .memAddr, .memWdata, .memRdata, .memAck, .pinOen, .pinOut, .extLow,
    .pinLevel(pinLvl));
  initial
  forever #5 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    $display("MISMATCH %0t timeout", $time);
    conclude();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    `WAITC(pready === 1'b1)
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // sources are held until reset is seen, then dropped
  task automatic wrst(int lim);
    int d = 0, c = 0;
    `WAITC(sysReset === 1'b1)
    {low_voltage_detect, cLoss, ilop, dbgRst, extLow} <= 5'h0;
    while (sysReset === 1'b1 && c + d < 400)
    begin
      `CHK({internal_clock_generator, pinsDef, spOut, ccrOut[3]}, {2'b11, 16'h00ff, 1'b1})
      if (pinOen === 1'b0)
        d++;
      else
        c++;
      @(posedge clk);
    end
    // the drive may start mid bus cycle, so count it in whole bus cycles
    `CHK((d + 1) / 2, 34)
    `CHK(c, 76)
    `WAITC(P.log.size() > 0)
    `CHK(P.log[0][23:8], 16'hfffe)
    `WAITC(cpuHold === 1'b0)
    P.log.delete();
  endtask
  task automatic fill(input logic [15:0] pc);
    for (int k = 0; k < 3; k++)
      exq.push_back({1'b0, pc + 16'(k), P.mem[pc + 16'(k)]});
  endtask
  task automatic match();
    `WAITC(P.log.size() >= exq.size() && cpuHold === 1'b0)
    foreach (exq[i]) `CHK(P.log[i], exq[i])
    `CHK(P.log.size(), exq.size())
    P.log.delete();
    exq.delete();
    $display("test sequence done");
  endtask
  task automatic entry(int s);
    logic [15:0] v;
    v = 16'hffc0 + 16'(2 * s);
    exq = '{{1'b1, 16'h00ff, pcNext[7:0]}, {1'b1, 16'h00fe, pcNext[15:8]}, {1'b1, 16'h00fd, idxIn},
      {1'b1, 16'h00fc, accIn}, {1'b1, 16'h00fb, ccrIn}, {1'b0, v, P.mem[v]}, {1'b0, v + 16'h1, P.mem[v + 16'h1]}};
    fill({P.mem[v], P.mem[v + 16'h1]});
    instrDone <= 1;
    @(posedge clk);
    instrDone <= 0;
    match();
    `CHK(pcOut, {P.mem[v], P.mem[v + 16'h1]})
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hfff9));
    repeat (2) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    wrst(5);
    apb(0, 8'h00, 0);
    `CHK(r, 32'h80)
    apb(0, 8'h04, 0);
    `CHK(r, 32'h3)
    apb(0, 8'h40, 0);
    `CHK({err, r}, 33'h100000000)
    for (int i = 0; i < 5; i++)
    begin
      {low_voltage_detect, cLoss, ilop, dbgRst, extLow} <= 5'h10 >> i;
      wrst(20);
      apb(0, 8'h00, 0);
      `CHK(r, {24'h0, srcFlag[i]})
    end
    $display("test reset sources done");
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 32'h1);
    apb(1, 8'h04, 32'h2);
    apb(0, 8'h04, 0);
    `CHK(r, 32'h5)
    repeat (20) apb(1, 8'h00, $urandom);
    apb(0, 8'h00, 0);
    `CHK({sysReset, r}, 33'h40)
    bdm <= 1;
    repeat (100) @(posedge clk);
    `CHK(sysReset, 1'b0)
    bdm <= 0;
    wrst(40);
    apb(0, 8'h00, 0);
    `CHK(r, 32'h20)
    repeat (60) @(posedge clk);
    `CHK(sysReset, 1'b0)
    wrst(120);
    $display("test watchdog done");
    apb(1, 8'h04, 32'h0);
    pcNext <= 16'($urandom);
    accIn <= 8'($urandom);
    idxIn <= 8'($urandom);
    ccrIn <= 8'($urandom) & 8'hf7;
    apb(1, 8'h0c, 32'h28);
    srcEvent <= 8'h28;
    @(posedge clk);
    srcEvent <= 0;
    apb(0, 8'h08, 0);
    `CHK(r, 32'h28)
    apb(1, 8'h10, 0);
    repeat (5) @(posedge clk);
    `CHK(memReq, 1'b0)
    entry(5);
    `CHK({spOut, ccrOut[3]}, {16'h00fa, 1'b1})
    apb(1, 8'h08, 32'h20);
    exq = '{{1'b0, 16'h00fb, ccrIn}, {1'b0, 16'h00fc, accIn}, {1'b0, 16'h00fd, idxIn},
      {1'b0, 16'h00fe, pcNext[15:8]}, {1'b0, 16'h00ff, pcNext[7:0]}};
    fill(pcNext);
    rtiStart <= 1;
    @(posedge clk);
    rtiStart <= 0;
    match();
    `CHK({spOut, pcOut, ccrOut, accOut, idxOut}, {16'h00ff, pcNext, ccrIn, accIn, idxIn})
    entry(3);
    for (int i = 0; i < 8; i++)
    begin
      {stopMode, irqPinEnable, irqPinRaw} <= 3'(i);
      @(posedge clk);
      #1 `CHK(stopWake, i == 6)
    end
    conclude();
  end
endmodule
`default_nettype wire
